// ---- bench/bid_core_props.sv ----
/* checker for bid_core: timing of the branch and the increment.
 * assumes one clock and sees only the block's ports. */
module bid_core_props import bid_pkg::*; (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic instr_valid_in,
	input wire logic [13:0] instr_in,
	input wire logic [7:0] pc_page_latch_in,
	input wire logic [12:0] pc_out,
	input wire logic pc_load_out,
	input wire logic [7:0] accum_out,
	input wire logic zero_flag_out,
	input wire logic [1:0] phase_out,
	input wire logic stall_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// outputs show one edge after the q4 edge
	// ----
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	wire take = phase_out == 2'h0 && instr_valid_in && !stall_out;
	wire br = take && instr_in[13:11] == BID_BRANCH_TOP;
	wire inc = take && instr_in[13:8] == BID_INCR_TOP;
	wire [1:0] pg = pc_page_latch_in[4:3];
	wire [10:0] lit = instr_in[10:0];
	a_phase_walk: assert property (1 |=> phase_out == $past(phase_out) + 2'h1)
		else $error("phase did not advance");
	a_branch_target: assert property (br |-> ##4 pc_load_out && pc_out == {$past(pg), $past(lit, 4)})
		else $error("branch target wrong");
	a_load_cause: assert property (pc_load_out |-> $past(br, 4))
		else $error("pc load without branch");
	a_stall_span: assert property (pc_load_out |-> stall_out[*4] ##1 !stall_out)
		else $error("stall cycle wrong");
	a_branch_flags: assert property (br |=> ($stable(zero_flag_out) && $stable(accum_out))[*8])
		else $error("branch touched flags");
	a_incr_zero: assert property (inc && !instr_in[7] |-> ##4 zero_flag_out == (accum_out == 8'h00))
		else $error("zero flag wrong");
	a_incr_keep: assert property (inc && instr_in[7] |-> ##4 accum_out == $past(accum_out) && !pc_load_out)
		else $error("accumulator written");
	a_zero_time: assert property ($changed(zero_flag_out) |-> $past(phase_out) == 2'h3)
		else $error("zero changed off q4");
	c_branch: cover property (br);
	c_wrap: cover property (inc ##4 zero_flag_out);
	c_wb: cover property (inc && instr_in[7]);
endmodule
bind bid_core bid_core_props i_bid_core_props (.*);

// ---- bench/tb.sv ----
/* bench for bid_core: one task per scenario, self checking.
 * assumes the hand-over timing; file contents loaded by software writes. */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 0, rst_in = 1, instr_valid_in = 0, file_wr_in = 0;
	logic [13:0] instr_in = 0;
	logic [7:0] pc_page_latch_in = 0, file_data_in = 0, accum_out, file_rd_data_out;
	logic [6:0] file_addr_in = 0;
	logic [12:0] pc_out;
	logic [1:0] phase_out;
	logic pc_load_out, zero_flag_out, stall_out;
	int err_count = 0, total_checks = 0;
	bid_core i_bid_core (.*);
	always #25 mclk_in = ~mclk_in;
	// ----
	// helpers
	// ----
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d, errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		file_wr_in <= 1'b1;
		file_addr_in <= a;
		file_data_in <= d;
		@(posedge mclk_in);
		file_wr_in <= 1'b0;
	endtask
	// nw/nv go on the pins at the write-back edge
	task exec(input logic [13:0] w, input logic [13:0] nw = 0, input logic nv = 0);
		logic [7:0] a0;
		@(negedge mclk_in);
		while (phase_out !== 2'h3) @(negedge mclk_in);
		@(posedge mclk_in);
		instr_in <= w;
		instr_valid_in <= 1'b1;
		@(posedge mclk_in);
		instr_valid_in <= 1'b0;
		@(negedge mclk_in);
		a0 = accum_out;
		repeat (2) @(posedge mclk_in);
		@(negedge mclk_in);
		chk(accum_out, a0);
		@(posedge mclk_in);
		instr_in <= nw;
		instr_valid_in <= nv;
		@(negedge mclk_in);
	endtask
	// ----
	// scenarios
	// ----
	task t_incr_acc;
		wr(7'h05, 8'hff);
		wr(7'h06, 8'h41);
		exec(14'h0a05);
		chk(accum_out, 8'h00);
		chk(zero_flag_out, 1'b1);
		exec(14'h0a06);
		chk(accum_out, 8'h42);
		chk(zero_flag_out, 1'b0);
	endtask
	task t_wb; // wrap in the register, accumulator kept
		exec(14'h0a85);
		chk(accum_out, 8'h42);
		chk(zero_flag_out, 1'b1);
	endtask
	task t_branch; // increment offered in the stall cycle must be dropped
		@(posedge mclk_in);
		pc_page_latch_in <= 8'h18;
		exec(14'h2da5, 14'h0a05, 1'b1);
		chk(pc_out, 13'h1da5);
		chk({pc_load_out, stall_out}, 2'h3);
		@(posedge mclk_in);
		instr_valid_in <= 1'b0;
		@(negedge mclk_in);
		chk(pc_load_out, 1'b0);
		repeat (4) @(negedge mclk_in);
		chk({zero_flag_out, accum_out}, 9'h142);
		chk(pc_out, 13'h1da5);
		@(posedge mclk_in);
		pc_page_latch_in <= 8'he7;
		exec(14'h2923);
		chk(pc_out, 13'h0123);
		exec(14'h2123);
		chk(pc_load_out, 1'b0);
		chk(pc_out, 13'h0124);
	endtask
	task t_file_port; // register 5 written back, register 6 left alone
		@(posedge mclk_in);
		file_addr_in <= 7'h05;
		repeat (8) @(posedge mclk_in);
		@(negedge mclk_in);
		chk(file_rd_data_out, 8'h00);
		@(posedge mclk_in);
		file_addr_in <= 7'h06;
		repeat (8) @(posedge mclk_in);
		@(negedge mclk_in);
		chk(file_rd_data_out, 8'h41);
	endtask
	task t_readback; // register 5 now holds zero
		exec(14'h0a05);
		chk(accum_out, 8'h01);
		chk(zero_flag_out, 1'b0);
	endtask
	initial begin
		#50000;
		err_count++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_incr_acc();
		t_wb();
		t_file_port();
		t_branch();
		t_readback();
		stop_test();
	end
endmodule

// ---- hdl/bid_core.sv ----
/*
 * decode and execute of the absolute branch and the file increment.
 * assumes the fetch path presents instr_in in phase one together with
 * instr_valid_in; other opcodes are ignored and act as one-cycle no-ops.
 */
// Implementation choices: the address-and-strobe port and the register offsets.
// Functional notes
// - branch loads literal into pc 10:0 and page latch 4:3 into pc 12:11
// - branch decoded from top bits 10, next bit 1, eleven literal bits
// - branch takes two cycles: pc written in q4, second cycle is no-op
// - branch leaves every status flag unchanged
// - increment decoded from 00 1010 d fffffff; d selects accumulator or file
// - increment sets zero flag from result, wrap to zero sets it
// - increment is one cycle: decode, read, process, write in q1..q4
module bid_core
	import bid_pkg::*;
#(
	parameter int IW = BID_IW,
	parameter int PCW = BID_PCW
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic instr_valid_in,
	input wire logic [IW-1:0] instr_in,
	input wire logic [BID_DW-1:0] pc_page_latch_in,
	input wire logic file_wr_in,
	input wire logic [BID_AW-1:0] file_addr_in,
	input wire logic [BID_DW-1:0] file_data_in,
	output logic [PCW-1:0] pc_out,
	output logic pc_load_out,
	output logic [BID_DW-1:0] accum_out,
	output logic zero_flag_out,
	output logic [1:0] phase_out,
	output logic stall_out,
	output logic [BID_DW-1:0] file_rd_data_out
);
	initial begin
		if (IW != BID_IW) begin
			$error("unsupported instruction width");
		end
		if (PCW != BID_PCW) begin
			$error("unsupported pc width");
		end
		// the branch target must fill the pc exactly
		if (BID_LIT_W + 2 != PCW) begin
			$error("literal and page bits do not fill the pc");
		end
		if (BID_PAGE_HI - BID_PAGE_LO != 1) begin
			$error("page field must be two bits");
		end
	end

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef enum logic [1:0] {BID_OP_NONE, BID_OP_BRANCH, BID_OP_INCR} bid_op_t;

	typedef struct packed {
		bid_phase_t phase;
		bid_op_t op;
		logic nop_cycle;
		logic [IW-1:0] instr;
		logic [PCW-1:0] pc;
		logic pc_load;
		logic [BID_DW-1:0] result;
		logic [BID_DW-1:0] accum;
		logic zero;
		logic [BID_DW-1:0] rd_data;
	} bid_state_t;

	bid_state_t s_reg;
	bid_state_t s_next;

	logic [BID_DW-1:0] mem_rd;
	logic mem_we;
	logic [BID_AW-1:0] mem_waddr;
	logic [BID_DW-1:0] mem_wdata;
	logic [BID_AW-1:0] mem_raddr;
	logic is_branch;
	logic is_incr;
	logic held_dest;
	logic [BID_AW-1:0] held_faddr;
	logic [BID_LIT_W-1:0] held_lit;
	logic [1:0] page_bits;
	logic core_wb;

	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	always_comb begin
		is_branch = instr_in[IW-1 -: 3] == BID_BRANCH_TOP;
		is_incr = instr_in[IW-1 -: 6] == BID_INCR_TOP;
	end

	// fields of the held word, used in the later phases
	always_comb begin
		held_dest = s_reg.instr[BID_DEST_BIT];
		held_faddr = s_reg.instr[BID_AW-1:0];
		held_lit = s_reg.instr[BID_LIT_W-1:0];
		page_bits = pc_page_latch_in[BID_PAGE_HI:BID_PAGE_LO];
		core_wb = s_reg.phase == BID_Q4 && s_reg.op == BID_OP_INCR && held_dest;
	end

	// --------------------------------------------------------------
	// file port: increment writes back in q4, else software port
	// --------------------------------------------------------------
	always_comb begin
		mem_raddr = held_faddr;
		if (s_reg.phase == BID_Q1) begin
			mem_raddr = file_addr_in;
		end
		mem_we = file_wr_in;
		mem_waddr = file_addr_in;
		mem_wdata = file_data_in;
		// core write wins; the software port should stay off the same q4
		if (core_wb) begin
			mem_we = 1'b1;
			mem_waddr = held_faddr;
			mem_wdata = s_reg.result;
		end
	end

	bid_file_mem #(
		.DEPTH(BID_REG_DEPTH),
		.AW(BID_AW),
		.DW(BID_DW)
	) u_mem (
		.mclk_in(mclk_in),
		.wr_en_in(mem_we),
		.wr_addr_in(mem_waddr),
		.wr_data_in(mem_wdata),
		.rd_addr_in(mem_raddr),
		.rd_data_out(mem_rd)
	);

	// --------------------------------------------------------------
	// quarter-phase sequencer
	// --------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.pc_load = 1'b0;
		unique case (s_reg.phase)
			BID_Q1: begin
				s_next.phase = BID_Q2;
				if (s_reg.nop_cycle) begin
					s_next.op = BID_OP_NONE;
				end else if (instr_valid_in && is_branch) begin
					s_next.op = BID_OP_BRANCH;
					s_next.instr = instr_in;
				end else if (instr_valid_in && is_incr) begin
					s_next.op = BID_OP_INCR;
					s_next.instr = instr_in;
				end else begin
					s_next.op = BID_OP_NONE;
				end
			end
			BID_Q2: begin
				s_next.phase = BID_Q3;
				// software read data, addressed during q1
				s_next.rd_data = mem_rd;
				// increment presents its file address now
			end
			BID_Q3: begin
				s_next.phase = BID_Q4;
				// the ram answers one clock late, so the operand lands here
				if (s_reg.op == BID_OP_INCR) begin
					// 8-bit wrap, no carry out kept
					s_next.result = mem_rd + 8'h01;
				end
			end
			BID_Q4: begin
				s_next.phase = BID_Q1;
				s_next.nop_cycle = 1'b0;
				if (s_reg.op == BID_OP_BRANCH) begin
					s_next.pc = {page_bits, held_lit};
					s_next.pc_load = 1'b1;
					s_next.nop_cycle = 1'b1;
					// flags deliberately untouched
				end else begin
					// the branch's idle cycle leaves the pc on the target
					if (!s_reg.nop_cycle) begin
						s_next.pc = s_reg.pc + 13'h0001;
					end
					if (s_reg.op == BID_OP_INCR) begin
						s_next.zero = s_reg.result == 8'h00;
						if (!held_dest) begin
							s_next.accum = s_reg.result;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			s_reg <= '{
				phase: BID_Q1,
				op: BID_OP_NONE,
				nop_cycle: 1'b0,
				instr: BID_INSTR_RST,
				pc: BID_PC_RST,
				pc_load: 1'b0,
				result: BID_DATA_RST,
				accum: BID_DATA_RST,
				zero: 1'b0,
				rd_data: BID_DATA_RST
			};
		end else begin
			s_reg <= s_next;
		end
	end

	// --------------------------------------------------------------
	// outputs, all from state flops
	// --------------------------------------------------------------
	always_comb begin
		pc_out = s_reg.pc;
		pc_load_out = s_reg.pc_load;
		accum_out = s_reg.accum;
		zero_flag_out = s_reg.zero;
		phase_out = s_reg.phase;
		stall_out = s_reg.nop_cycle;
		file_rd_data_out = s_reg.rd_data;
	end
endmodule

// ---- hdl/bid_file_mem.sv ----
/*
 * small register file for the decode block, one write port and one
 * registered read port.
 * assumes write and read addresses come from the same clock domain.
 */
module bid_file_mem
	import bid_pkg::*;
#(
	parameter int DEPTH = BID_REG_DEPTH,
	parameter int AW = BID_AW,
	parameter int DW = BID_DW
) (
	input wire logic mclk_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [DW-1:0] wr_data_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [DW-1:0] rd_data_out
);
	initial begin
		if (DEPTH > (1 << AW)) $error("depth exceeds address range");
	end

	logic [DW-1:0] mem [DEPTH];

	// no reset on the array: contents are software defined
	always_ff @(posedge mclk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule

// ---- hdl/bid_pkg.sv ----
/*
 * package for the branch / increment decode block: encodings, field
 * positions, reset values and the quarter-phase enumeration.
 * assumes a single core clock; one instruction cycle is four clocks.
 */
package bid_pkg;
	// --------------------------------------------------------------
	// widths
	// --------------------------------------------------------------
	localparam int BID_IW = 14;
	localparam int BID_PCW = 13;
	localparam int BID_DW = 8;
	localparam int BID_AW = 7;
	// --------------------------------------------------------------
	// encodings and fields
	// --------------------------------------------------------------
	localparam logic [2:0] BID_BRANCH_TOP = 3'h5;
	localparam logic [5:0] BID_INCR_TOP = 6'h0a;
	localparam int BID_BRANCH_TOP_LSB = 11;
	localparam int BID_INCR_TOP_LSB = 8;
	localparam int BID_DEST_BIT = 7;
	localparam int BID_LIT_W = 11;
	localparam int BID_PAGE_HI = 4;
	localparam int BID_PAGE_LO = 3;
	// --------------------------------------------------------------
	// reset values and counts
	// --------------------------------------------------------------
	localparam logic [12:0] BID_PC_RST = 13'h0000;
	localparam logic [7:0] BID_DATA_RST = 8'h00;
	localparam logic [13:0] BID_INSTR_RST = 14'h0000;
	localparam int BID_BRANCH_CYCLES = 2;
	localparam int BID_REG_DEPTH = 128;

	typedef enum logic [1:0] {BID_Q1, BID_Q2, BID_Q3, BID_Q4} bid_phase_t;
endpackage
